// file: hw/ftb_pkg.sv
// package for the fan speed input binding and monitor status/control block
// assumes a byte-wide register port driven by the two-wire interface front end
// ----------------------------------------------------------------------------
// Contract
// R1 - eight binding bits, two per speed input; low bit drive a, high bit drive b
// R2 - mask speed errors of inputs bound to a drive at zero duty or spin-up
// R3 - software never binds one speed input to both drives
// R4 - software programs the binding whenever smart tachometer mode is on
// R5 - override bit 0 forces every drive output to full duty
// R6 - with bit 2 set, general input four error masks all other error events
// R7 - bits 5:4 pick tachometer edges: either, rising, falling, 3 reserved
// R8 - duty changing from zero to non-zero starts spin-up for configured time
// R9 - bit 6 shows any host error, bit 7 any board-controller error
// ----------------------------------------------------------------------------
package ftb_pkg;
  localparam logic [7:0] ADDR_BINDING = 8'hE0;
  localparam logic [7:0] ADDR_STATUS_CTRL = 8'hE2;
  localparam logic [7:0] RESET_BINDING = 8'h00;
  localparam logic [7:0] RESET_STATUS_CTRL = 8'h00;
  localparam int BIT_OVERRIDE = 0;
  localparam int BIT_ASF_MODE = 1;
  localparam int BIT_TRIP_A_MASK = 2;
  localparam int BIT_TRIP_B_MASK = 3;
  localparam int BIT_EDGE_LO = 4;
  localparam int BIT_HOST_SUM = 6;
  localparam int BIT_BOARD_SUM = 7;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam int CLOCK_MHZ = 125;
  // spin-up times in ms, index is the three-bit duration code
  localparam int SPINUP_MS [8] = '{0, 100, 250, 400, 700, 1000, 2000, 4000};
  localparam int CYCLES_PER_MS = CLOCK_MHZ * 1000;
  typedef enum logic [1:0] {EDGE_EITHER, EDGE_RISE, EDGE_FALL, EDGE_RSVD} ftb_edge_e;
endpackage

// file: hw/ftb_spinup.sv
// spin-up timer for one fan drive output
// assumes duty is synchronous to clock and tick is a one-cycle ms strobe
`timescale 1ns/1ps
module ftb_spinup
  import ftb_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic clockEnable,
  // control
  input wire logic msTick,
  input wire logic [7:0] duty,
  input wire logic [2:0] spinupDuration,
  // status
  output logic spinning
);
  logic [7:0] prevDuty;
  logic [11:0] msLeft;
  logic spinActive;
  logic startNow;

  // R8 zero to nonzero starts spin-up
  assign startNow = (prevDuty == DUTY_ZERO) && (duty != DUTY_ZERO) && (spinupDuration != 3'h0);
  // the starting cycle counts as spinning, so no speed error slips through it
  assign spinning = spinActive || startNow;

  // R8 spin-up countdown in ms ticks
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prevDuty <= DUTY_ZERO;
      msLeft <= 12'h000;
      spinActive <= 1'b0;
    end else if (clockEnable) begin
      prevDuty <= duty;
      if (startNow) begin
        msLeft <= 12'(SPINUP_MS[spinupDuration]);
        spinActive <= 1'b1;
      end else if (duty == DUTY_ZERO) begin
        msLeft <= 12'h000;
        spinActive <= 1'b0;
      end else if (spinActive && msTick) begin
        msLeft <= msLeft - 12'h001;
        if (msLeft == 12'h001) spinActive <= 1'b0;
      end
    end
  end
endmodule

// file: hw/ftb_binding_ctrl.sv
// tachometer to drive binding, override, auto-mask and status/control registers
// assumes a byte register port and error vectors from the monitor's status logic
`timescale 1ns/1ps
module ftb_binding_ctrl
  import ftb_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS,
  parameter int HOST_ERR_W = 8,
  parameter int BOARD_ERR_W = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic clockEnable,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  // automatic fan control duty and spin-up settings
  input wire logic [7:0] autoDutyA,
  input wire logic [7:0] autoDutyB,
  input wire logic [2:0] spinupDurationA,
  input wire logic [2:0] spinupDurationB,
  // raw error events and status views
  input wire logic [3:0] speedErrRaw,
  input wire logic [15:0] otherErrRaw,
  input wire logic generalInputFourErr,
  input wire logic generalInputFourErrCleared,
  input wire logic [HOST_ERR_W-1:0] hostErrStatus,
  input wire logic [BOARD_ERR_W-1:0] boardErrStatus,
  // outputs
  output logic [7:0] fanDriveOutA,
  output logic [7:0] fanDriveOutB,
  output logic [1:0] tachEdgeSel,
  output logic [3:0] speedErrEvent,
  output logic [15:0] otherErrEvent,
  output logic generalInputFourEvent,
  output logic alertStandardFormatMode,
  output logic tripInputBAutoMask
);
  // ---------------------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------------------
  // the ms strobe needs at least two cycles per period
  if (MS_CYCLES < 2) begin : gMsCyclesCheck
    $error("MS_CYCLES must be at least 2");
  end
  // each status vector must carry at least one bit
  if (HOST_ERR_W < 1 || BOARD_ERR_W < 1) begin : gErrWidthCheck
    $error("error widths must be positive");
  end

  logic [7:0] binding;
  logic fullSpeedOverride, tripInputAAutoMask;
  logic [1:0] edgeField;
  logic tripLatched;
  logic [31:0] msCount;
  logic msTick;
  logic spinA, spinB;
  logic [3:0] speedMask;
  logic hostSum, boardSum;

  // ---------------------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------------------
  // R1 binding storage
  always_ff @(posedge clock) begin
    if (!nrst) begin
      binding <= RESET_BINDING;
    end else if (clockEnable && regWrite && regAddr == ADDR_BINDING) begin
      binding <= regWdata;
    end
  end

  // control bits of the status/control register
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fullSpeedOverride <= RESET_STATUS_CTRL[BIT_OVERRIDE];
      alertStandardFormatMode <= RESET_STATUS_CTRL[BIT_ASF_MODE];
      tripInputAAutoMask <= RESET_STATUS_CTRL[BIT_TRIP_A_MASK];
      tripInputBAutoMask <= RESET_STATUS_CTRL[BIT_TRIP_B_MASK];
      edgeField <= RESET_STATUS_CTRL[BIT_EDGE_LO+:2];
    end else if (clockEnable && regWrite && regAddr == ADDR_STATUS_CTRL) begin
      fullSpeedOverride <= regWdata[BIT_OVERRIDE];
      alertStandardFormatMode <= regWdata[BIT_ASF_MODE];
      tripInputAAutoMask <= regWdata[BIT_TRIP_A_MASK];
      tripInputBAutoMask <= regWdata[BIT_TRIP_B_MASK];
      edgeField <= regWdata[BIT_EDGE_LO+:2];
    end
  end

  // ---------------------------------------------------------------------------
  // spin-up timing
  // ---------------------------------------------------------------------------
  // millisecond strobe shared by both timers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      msCount <= 32'h0000_0000;
      msTick <= 1'b0;
    end else if (clockEnable) begin
      msTick <= (msCount == 32'(MS_CYCLES - 1));
      msCount <= (msCount == 32'(MS_CYCLES - 1)) ? 32'h0000_0000 : msCount + 32'h0000_0001;
    end
  end

  // one spin-up timer per drive output
  ftb_spinup spinupA (
    .clock(clock),
    .nrst(nrst),
    .clockEnable(clockEnable),
    .msTick(msTick),
    .duty(autoDutyA),
    .spinupDuration(spinupDurationA),
    .spinning(spinA)
  );
  ftb_spinup spinupB (
    .clock(clock),
    .nrst(nrst),
    .clockEnable(clockEnable),
    .msTick(msTick),
    .duty(autoDutyB),
    .spinupDuration(spinupDurationB),
    .spinning(spinB)
  );

  // ---------------------------------------------------------------------------
  // drive outputs and edge select
  // ---------------------------------------------------------------------------
  // R5 full speed override
  always_ff @(posedge clock) begin
    if (!nrst) begin
      fanDriveOutA <= DUTY_ZERO;
      fanDriveOutB <= DUTY_ZERO;
    end else if (clockEnable) begin
      fanDriveOutA <= fullSpeedOverride ? DUTY_FULL : autoDutyA;
      fanDriveOutB <= fullSpeedOverride ? DUTY_FULL : autoDutyB;
    end
  end

  // R7 edge selection, reserved code falls back to either edge
  // the stored field still reads back as written, reserved code included
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tachEdgeSel <= 2'(EDGE_EITHER);
    end else if (clockEnable) begin
      tachEdgeSel <= (edgeField == 2'(EDGE_RSVD)) ? 2'(EDGE_EITHER) : edgeField;
    end
  end

  // ---------------------------------------------------------------------------
  // error masking
  // ---------------------------------------------------------------------------
  // R2 speed error mask from binding
  // an input bound to both drives is masked by either, software must avoid that
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      speedMask[i] = (binding[2*i] && (autoDutyA == DUTY_ZERO || spinA))
                  || (binding[2*i+1] && (autoDutyB == DUTY_ZERO || spinB));
    end
  end

  // R6 trip latch, set wins over clear
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tripLatched <= 1'b0;
    end else if (clockEnable) begin
      if (tripInputAAutoMask && generalInputFourErr) tripLatched <= 1'b1;
      else if (generalInputFourErrCleared || !tripInputAAutoMask) tripLatched <= 1'b0;
    end
  end

  // R6 mask other events after trip
  // the trip event masks the others in its own cycle, before the latch is set
  always_ff @(posedge clock) begin
    if (!nrst) begin
      speedErrEvent <= 4'h0;
      otherErrEvent <= 16'h0000;
      generalInputFourEvent <= 1'b0;
    end else if (clockEnable) begin
      generalInputFourEvent <= generalInputFourErr && !tripLatched;
      if (tripLatched || (tripInputAAutoMask && generalInputFourErr)) begin
        speedErrEvent <= 4'h0;
        otherErrEvent <= 16'h0000;
      end else begin
        speedErrEvent <= speedErrRaw & ~speedMask;
        otherErrEvent <= otherErrRaw;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // summaries and readback
  // ---------------------------------------------------------------------------
  // R9 summary flags
  // flags trail the status bits by one cycle, a read adds one more
  always_ff @(posedge clock) begin
    if (!nrst) begin
      hostSum <= 1'b0;
      boardSum <= 1'b0;
    end else if (clockEnable) begin
      hostSum <= |hostErrStatus;
      boardSum <= |boardErrStatus;
    end
  end

  // read data register, unmapped reads return zero
  always_ff @(posedge clock) begin
    if (!nrst) begin
      regRdata <= 8'h00;
    end else if (clockEnable && regRead) begin
      if (regAddr == ADDR_BINDING) begin
        regRdata <= binding;
      end else if (regAddr == ADDR_STATUS_CTRL) begin
        regRdata <= {boardSum, hostSum, edgeField, tripInputBAutoMask,
                     tripInputAAutoMask, alertStandardFormatMode, fullSpeedOverride};
      end else begin
        regRdata <= 8'h00;
      end
    end
  end
endmodule

// file: test/ftb_binding_ctrl_properties.sv
// port assertions for the binding and status/control block
// assumes clockEnable held high and registers reached only by the byte port
`timescale 1ns/1ps
module ftb_binding_ctrl_properties
  import ftb_pkg::*;
#(parameter int HOST_ERR_W = 8, parameter int BOARD_ERR_W = 8) (
  // clock, reset and register port
  input wire logic clock, nrst, regWrite, regRead,
  input wire logic [7:0] regAddr, regWdata, regRdata, autoDutyA, fanDriveOutA, fanDriveOutB,
  // error paths and outputs
  input wire logic [2:0] spinupDurationA,
  input wire logic [3:0] speedErrRaw, speedErrEvent,
  input wire logic [15:0] otherErrEvent,
  input wire logic [HOST_ERR_W-1:0] hostErrStatus,
  input wire logic [BOARD_ERR_W-1:0] boardErrStatus,
  input wire logic generalInputFourEvent, generalInputFourErrCleared,
  input wire logic [1:0] tachEdgeSel
);
  logic [7:0] bnd;
  logic [5:0] ctl;
  // shadow copies of the two writable registers
  always_ff @(posedge clock) begin
    if (!nrst) begin
      bnd <= RESET_BINDING;
      ctl <= 6'h00;
    end else if (regWrite) begin
      if (regAddr == ADDR_BINDING) bnd <= regWdata;
      if (regAddr == ADDR_STATUS_CTRL) ctl <= regWdata[5:0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_ovr; ctl[0] && !regWrite |=> fanDriveOutA == DUTY_FULL && fanDriveOutB == DUTY_FULL;
  endproperty
  a_ovr: assert property (p_ovr) else $error("drive not full under override");
  property p_edge; !regWrite |=> tachEdgeSel == ($past(ctl[5:4]) == 2'd3 ? 2'd0 : $past(ctl[5:4]));
  endproperty
  a_edge: assert property (p_edge) else $error("edge select mismatch");
  property p_zero; speedErrRaw[0] && bnd == 8'h01 && autoDutyA == DUTY_ZERO && !ctl[0] && !regWrite
    |=> speedErrEvent[0] == 1'b0; endproperty
  a_zero: assert property (p_zero) else $error("speed error passed at zero duty");
  property p_free; speedErrRaw[1] && bnd[3:2] == 2'b00 && !ctl[2] && !$past(ctl[2]) && !regWrite
    |=> speedErrEvent[1]; endproperty
  a_free: assert property (p_free) else $error("unbound speed error lost");
  property p_spin; $past(autoDutyA) == DUTY_ZERO && autoDutyA != DUTY_ZERO && spinupDurationA != 3'h0
    && bnd == 8'h01 && !ctl[0] |-> ##3 (speedErrEvent[0] == 1'b0) [*4]; endproperty
  a_spin: assert property (p_spin) else $error("speed error passed during spin-up");
  property p_trip; ctl[2] && generalInputFourEvent && !generalInputFourErrCleared && !regWrite
    |=> otherErrEvent == 16'h0000; endproperty
  a_trip: assert property (p_trip) else $error("event passed after trip input");
  property p_sum; regRead && regAddr == ADDR_STATUS_CTRL |=>
    regRdata[7:6] == {|$past(boardErrStatus, 2), |$past(hostErrStatus, 2)}; endproperty
  a_sum: assert property (p_sum) else $error("summary flags mismatch");
  property p_bind; regRead && regAddr == ADDR_BINDING && !regWrite |=> regRdata == $past(bnd);
  endproperty
  a_bind: assert property (p_bind) else $error("binding readback mismatch");
  c_ovr: cover property (ctl[0] && fanDriveOutA == DUTY_FULL);
  c_trip: cover property (ctl[2] && generalInputFourEvent);
  c_spin: cover property (p_spin);
endmodule
bind ftb_binding_ctrl ftb_binding_ctrl_properties
  #(.HOST_ERR_W(HOST_ERR_W), .BOARD_ERR_W(BOARD_ERR_W)) chk_u (.*);

// file: test/ftb_host_model.sv
// host software model issuing single byte register accesses
// assumes one calling process at a time
`timescale 1ns/1ps
module ftb_host_model
  import ftb_pkg::*;
(
  // clock
  input wire logic clock,
  // register port
  output logic regWrite,
  output logic regRead,
  output logic [7:0] regAddr,
  output logic [7:0] regWdata
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
  end
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
    @(posedge clock);
    #1;
    regWrite = wr;
    regRead = !wr;
    regAddr = addr;
    regWdata = data;
    @(posedge clock);
    #1;
    regWrite = 1'b0;
    regRead = 1'b0;
  endtask
endmodule

// file: test/tb_fan_tach_binding_status_ctrl.sv
// self-checking bench for the binding and status/control block
// assumes the host model drives the register port
`timescale 1ns/1ps
module tb_fan_tach_binding_status_ctrl;
  import ftb_pkg::*;
  logic clock = 1'b0, nrst = 1'b0, clockEnable = 1'b1, regWrite, regRead;
  logic generalInputFourErr, generalInputFourErrCleared, generalInputFourEvent;
  logic alertStandardFormatMode, tripInputBAutoMask;
  logic [7:0] regAddr, regWdata, regRdata, autoDutyA, autoDutyB, fanDriveOutA, fanDriveOutB;
  logic [7:0] hostErrStatus, boardErrStatus, d, q[$];
  logic [2:0] spinupDurationA, spinupDurationB;
  logic [3:0] speedErrRaw, speedErrEvent;
  logic [15:0] otherErrRaw, otherErrEvent;
  logic [1:0] tachEdgeSel;
  int failCount = 0, samplesChecked = 0, cycles = 0, i;
  ftb_binding_ctrl #(.MS_CYCLES(4)) dut_u (.*);
  ftb_host_model host_u (.*);
  always #4 clock = ~clock;
  // compare one read result
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR regRdata expected %h seen %h", exp, got);
    end
  endtask
  // compare one output level
  task automatic chkOut(input string name, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      failCount++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    host_u.access(1'b0, a, 8'h00);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic completeRun();
    $display("compared %0d mismatched %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // read results settle by the following falling edge
  always @(posedge clock) begin
    if (regRead) begin
      @(negedge clock);
      chk(q.pop_front(), regRdata);
    end
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      failCount++;
      completeRun();
    end
  end
  initial begin
    {autoDutyA, autoDutyB, hostErrStatus, boardErrStatus} = 32'h0000_0000;
    {spinupDurationA, spinupDurationB, speedErrRaw, otherErrRaw} = 26'h000_0000;
    {generalInputFourErr, generalInputFourErrCleared} = 2'b00;
    d = 8'($urandom(84));
    step(5);
    nrst = 1'b1;
    rd(ADDR_BINDING, RESET_BINDING);
    rd(ADDR_STATUS_CTRL, RESET_STATUS_CTRL);
    host_u.access(1'b1, 8'hE1, 8'h5A);
    rd(8'hE1, 8'h00);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      d = 8'($urandom);
      d = d & ~((d & 8'h55) << 1);
      host_u.access(1'b1, ADDR_BINDING, d);
      rd(ADDR_BINDING, d);
      d = {2'b00, 2'(i), 4'h0};
      host_u.access(1'b1, ADDR_STATUS_CTRL, d);
      rd(ADDR_STATUS_CTRL, d);
      chkOut("tachEdgeSel", (i == 3) ? 16'h0000 : 16'(i), 16'(tachEdgeSel));
    end
    $display("binding and edge test done");
    autoDutyA = 8'($urandom);
    autoDutyB = 8'($urandom);
    host_u.access(1'b1, ADDR_STATUS_CTRL, 8'h0B);
    step(4);
    rd(ADDR_STATUS_CTRL, 8'h0B);
    chkOut("fanDriveOutA", 16'(DUTY_FULL), 16'(fanDriveOutA));
    chkOut("fanDriveOutB", 16'(DUTY_FULL), 16'(fanDriveOutB));
    chkOut("ctrlBits", 16'h0003, 16'({alertStandardFormatMode, tripInputBAutoMask}));
    $display("override test done");
    host_u.access(1'b1, ADDR_STATUS_CTRL, 8'h00);
    host_u.access(1'b1, ADDR_BINDING, 8'h01);
    {autoDutyA, spinupDurationA, speedErrRaw} = {8'h00, 3'h1, 4'hF};
    step(10);
    chkOut("speedErrEvent", 16'h000E, 16'(speedErrEvent));
    chkOut("fanDriveOutB", 16'(autoDutyB), 16'(fanDriveOutB));
    autoDutyA = 8'h80;
    step(1);
    chkOut("speedErrEvent", 16'h000E, 16'(speedErrEvent));
    step(200);
    chkOut("speedErrEvent", 16'h000E, 16'(speedErrEvent));
    step(300);
    chkOut("speedErrEvent", 16'h000F, 16'(speedErrEvent));
    speedErrRaw = 4'h0;
    $display("spin-up test done");
    host_u.access(1'b1, ADDR_STATUS_CTRL, 8'h04);
    otherErrRaw = 16'($urandom) | 16'h0001;
    generalInputFourErr = 1'b1;
    step(1);
    chkOut("generalInputFourEvent", 16'h0001, 16'(generalInputFourEvent));
    chkOut("otherErrEvent", 16'h0000, otherErrEvent);
    generalInputFourErr = 1'b0;
    step(6);
    chkOut("otherErrEvent", 16'h0000, otherErrEvent);
    generalInputFourErrCleared = 1'b1;
    step(1);
    generalInputFourErrCleared = 1'b0;
    step(1);
    chkOut("otherErrEvent", otherErrRaw, otherErrEvent);
    {otherErrRaw, hostErrStatus} = {16'h0000, 8'h10};
    step(3);
    rd(ADDR_STATUS_CTRL, 8'h44);
    {hostErrStatus, boardErrStatus} = 16'h0001;
    step(3);
    rd(ADDR_STATUS_CTRL, 8'h84);
    d = autoDutyB;
    clockEnable = 1'b0;
    autoDutyB = ~autoDutyB;
    step(3);
    chkOut("fanDriveOutB", 16'(d), 16'(fanDriveOutB));
    clockEnable = 1'b1;
    step(2);
    $display("trip and summary test done");
    completeRun();
  end
endmodule
